// File: src/combination_function_cells.sv
// Purpose: Combination function cells: three two-input table/flop cells,
//          one table/pattern generator cell, one three-input table/flop
//          cell with set/reset, configured over classic Wishbone.
// Assumes: Routed inputs are synchronous to core_clk_i; routed "clocks"
//          are sampled and their edges detected in the core clock.
// Notes:   Each cell output is registered, so a table output lags its inputs
//          by one core clock and an edge-clocked output lags its edge by two.
//
// What this block does
// - configuration bits choose each cell's function; signals come from routing.
// - cell A table outputs entry selected by inputs, entry 0 for 00.
// - cell B table outputs entry selected by inputs, entry 0 for 00.
// - cell C table outputs entry selected by inputs, entry 0 for 00.
// - gate tables MSB first: AND 1000, OR 1110, XOR 0110 and inverses.
// - two-input flop uses input zero as data, input one as clock.
// - flop loads data on rising clock edge, holds otherwise.
// - latch is transparent while clock low, holds while clock high.
// - one configuration bit selects pattern generator reset level.
// - pattern generator repeats a user pattern of two to sixteen bits.
// - pattern cell table outputs entry selected by its two inputs.
// - three-input table combines three routed inputs into one output.
// - three-input flop takes data, clock and combined set/reset.
// - one configuration bit selects set/reset active level.
// - split-edge flop with mode bit 0 loads on rising edge.
// - split-edge mode 1 captures on rising, shows on falling edge.
// - three-input table outputs entry selected by three inputs.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defines.svh"

module combination_function_cells
(
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Routed inputs, bit 0 is select_input_zero.
    input  wire logic [1:0]  table_a_in_i,
    input  wire logic [1:0]  table_b_in_i,
    input  wire logic [1:0]  table_c_in_i,
    input  wire logic [1:0]  pattern_in_i,
    input  wire logic [2:0]  three_in_i,
    // Cell outputs back to routing.
    output logic             table_a_out_o,
    output logic             table_b_out_o,
    output logic             table_c_out_o,
    output logic             pattern_out_o,
    output logic             three_out_o
);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [3:0]                 tbl2_q [3];
    logic [3:0]                 tbl_pg_q;
    logic [7:0]                 tbl3_q;
    logic [`CFC_MODE_W-1:0]     mode_q;
    logic [`CFC_PAT_W-1:0]      pattern_q;
    logic [`CFC_PLEN_W-1:0]     plen_q;
    logic                       ack_q;
    logic [31:0]                rdata_q;
    logic                       bus_req;
    logic                       wr_req;
    logic                       lane0;
    logic                       lane1;

    // A request is taken once per strobe; ack drops the cycle after.
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_req  = bus_req & wb_we_i;
    assign lane0   = wb_sel_i[0];
    assign lane1   = wb_sel_i[1];

    // Register writes; byte lanes 0 and 1 carry every field.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tbl2_q[0] <= `CFC_RST_TBL2;
            tbl2_q[1] <= `CFC_RST_TBL2;
            tbl2_q[2] <= `CFC_RST_TBL2;
            tbl_pg_q  <= `CFC_RST_TBL2;
            tbl3_q    <= `CFC_RST_TBL3;
            mode_q    <= `CFC_RST_MODE;
            pattern_q <= `CFC_RST_PATTERN;
            plen_q    <= `CFC_RST_PLEN;
        end
        else if (clk_en_i && wr_req)
        begin
            case (wb_adr_i)
                `CFC_OFF_TBL_A:
                    if (lane0) tbl2_q[0] <= wb_dat_i[3:0];
                `CFC_OFF_TBL_B:
                    if (lane0) tbl2_q[1] <= wb_dat_i[3:0];
                `CFC_OFF_TBL_C:
                    if (lane0) tbl2_q[2] <= wb_dat_i[3:0];
                `CFC_OFF_TBL_PG:
                    if (lane0) tbl_pg_q <= wb_dat_i[3:0];
                `CFC_OFF_TBL_3A:
                    if (lane0) tbl3_q <= wb_dat_i[7:0];
                `CFC_OFF_MODE:
                begin
                    if (lane0) mode_q[7:0] <= wb_dat_i[7:0];
                    if (lane1)
                        mode_q[`CFC_MODE_W-1:8] <=
                            wb_dat_i[`CFC_MODE_W-1:8];
                end
                `CFC_OFF_PATTERN:
                begin
                    if (lane0) pattern_q[7:0]  <= wb_dat_i[7:0];
                    if (lane1) pattern_q[15:8] <= wb_dat_i[15:8];
                end
                `CFC_OFF_PLEN:
                    if (lane0) plen_q <= wb_dat_i[`CFC_PLEN_W-1:0];
                default:
                    ; // Unmapped and read-only offsets ignore writes.
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Edge detection of the routed clocks
    // ------------------------------------------------------------------
    logic [2:0] clk2;
    logic [2:0] clk2_prev_q;
    logic [2:0] rise2;
    logic       pg_clk_prev_q;
    logic       pg_rise;
    logic       c3_prev_q;
    logic       c3_rise;
    logic       c3_fall;

    assign clk2    = {table_c_in_i[1], table_b_in_i[1], table_a_in_i[1]};
    assign rise2   = clk2 & ~clk2_prev_q;
    assign pg_rise = pattern_in_i[0] & ~pg_clk_prev_q;
    assign c3_rise = three_in_i[1] & ~c3_prev_q;
    assign c3_fall = ~three_in_i[1] & c3_prev_q;

    // The previous levels make single-cycle edge strobes.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            clk2_prev_q   <= 3'h0;
            pg_clk_prev_q <= 1'b0;
            c3_prev_q     <= 1'b0;
        end
        else if (clk_en_i)
        begin
            clk2_prev_q   <= clk2;
            pg_clk_prev_q <= pattern_in_i[0];
            c3_prev_q     <= three_in_i[1];
        end
    end

    // ------------------------------------------------------------------
    // Two-input cells A, B and C
    // ------------------------------------------------------------------
    logic [1:0] in2 [3];
    logic [2:0] q2_q;
    logic [2:0] out2_d;
    logic [2:0] out2_q;

    assign in2[0] = table_a_in_i;
    assign in2[1] = table_b_in_i;
    assign in2[2] = table_c_in_i;

    for (genvar g = 0; g < 3; g++)
    begin : g_two_input
        logic seq;
        logic lat;

        assign seq = mode_q[`CFC_MODE_SEQ_LO + g];
        assign lat = mode_q[`CFC_MODE_LAT_LO + g];

        // Storage: edge flop or low-transparent latch, data on input 0.
        always_ff @(posedge core_clk_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
                q2_q[g] <= 1'b0;
            else if (clk_en_i && seq)
            begin
                if (!lat && rise2[g])
                    q2_q[g] <= in2[g][0];
                else if (lat && !in2[g][1])
                    q2_q[g] <= in2[g][0];
            end
        end

        // Table entry 0 answers pattern 00, entry 3 answers 11.
        assign out2_d[g] = seq ? q2_q[g]
                               : tbl2_q[g][in2[g]];
    end

    // Outputs are retimed so routing sees clean flop outputs.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            out2_q <= 3'h0;
        else if (clk_en_i)
            out2_q <= out2_d;
    end

    assign table_a_out_o = out2_q[0];
    assign table_b_out_o = out2_q[1];
    assign table_c_out_o = out2_q[2];

    // ------------------------------------------------------------------
    // Pattern cell: table or pattern generator
    // ------------------------------------------------------------------
    cfc_pkg::pg_state_e pg_state_q;
    cfc_pkg::pg_index_t pg_idx_q;
    logic               pg_en;
    logic               pg_rst_act;
    logic               pg_last;
    logic               pg_out_d;
    logic               pg_out_q;
    logic [3:0]         pg_top;

    assign pg_en = mode_q[`CFC_MODE_PG_EN];
    // Reset is input one; the mode bit picks high or low activity.
    assign pg_rst_act = pattern_in_i[1] ~^ mode_q[`CFC_MODE_PG_HIGH];
    // A length code of 0 would be one bit; it is treated as two.
    assign pg_top  = (plen_q == 4'h0) ? 4'h1 : plen_q;
    assign pg_last = (pg_idx_q >= pg_top);

    // Step one bit per rising clock, wrap after the last one.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pg_state_q <= cfc_pkg::PG_HELD;
            pg_idx_q   <= 4'h0;
        end
        else if (clk_en_i)
        begin
            case (pg_state_q)
                cfc_pkg::PG_HELD:
                begin
                    pg_idx_q <= 4'h0;
                    if (pg_en && !pg_rst_act)
                        pg_state_q <= cfc_pkg::PG_RUN;
                end
                cfc_pkg::PG_RUN:
                begin
                    if (!pg_en || pg_rst_act)
                    begin
                        pg_state_q <= cfc_pkg::PG_HELD;
                        pg_idx_q   <= 4'h0;
                    end
                    else if (pg_rise)
                        pg_idx_q <= pg_last ? 4'h0
                                            : pg_idx_q + 4'h1;
                end
                default:
                    pg_state_q <= cfc_pkg::PG_HELD;
            endcase
        end
    end

    assign pg_out_d = pg_en ? pattern_q[pg_idx_q]
                            : tbl_pg_q[pattern_in_i];

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pg_out_q <= 1'b0;
        else if (clk_en_i)
            pg_out_q <= pg_out_d;
    end

    assign pattern_out_o = pg_out_q;

    // ------------------------------------------------------------------
    // Three-input cell: table, flop, split-edge flop or latch
    // ------------------------------------------------------------------
    logic c3_seq;
    logic c3_lat;
    logic c3_split;
    logic c3_sr_act;
    logic c3_sr_val;
    logic c3_cap_q;
    logic c3_q_q;
    logic c3_out_d;
    logic c3_out_q;

    // Table entries 2 and 4 double as flop options, as in the device.
    assign c3_seq    = mode_q[`CFC_MODE_SEQ3];
    assign c3_lat    = mode_q[`CFC_MODE_LAT3];
    assign c3_split  = tbl3_q[`CFC_T3_SPLIT];
    assign c3_sr_val = mode_q[`CFC_MODE_SET3];
    assign c3_sr_act = three_in_i[2] ~^ tbl3_q[`CFC_T3_SR_HIGH];

    // Set/reset wins over the clock; data is input 0, clock input 1.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            c3_cap_q <= 1'b0;
            c3_q_q   <= 1'b0;
        end
        else if (clk_en_i && c3_seq)
        begin
            if (c3_sr_act)
            begin
                c3_cap_q <= c3_sr_val;
                c3_q_q   <= c3_sr_val;
            end
            else if (c3_lat)
            begin
                if (!three_in_i[1])
                    c3_q_q <= three_in_i[0];
            end
            else if (!c3_split)
            begin
                if (c3_rise)
                    c3_q_q <= three_in_i[0];
            end
            else
            begin
                if (c3_rise)
                    c3_cap_q <= three_in_i[0];
                if (c3_fall)
                    c3_q_q <= c3_cap_q;
            end
        end
    end

    assign c3_out_d = c3_seq ? c3_q_q
                             : tbl3_q[three_in_i];

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            c3_out_q <= 1'b0;
        else if (clk_en_i)
            c3_out_q <= c3_out_d;
    end

    assign three_out_o = c3_out_q;

    // ------------------------------------------------------------------
    // Wishbone read data and acknowledge
    // ------------------------------------------------------------------
    logic [31:0] rdata_d;

    // Status shows the live cell outputs and the pattern position.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `CFC_OFF_TBL_A:   rdata_d[3:0] = tbl2_q[0];
            `CFC_OFF_TBL_B:   rdata_d[3:0] = tbl2_q[1];
            `CFC_OFF_TBL_C:   rdata_d[3:0] = tbl2_q[2];
            `CFC_OFF_TBL_PG:  rdata_d[3:0] = tbl_pg_q;
            `CFC_OFF_TBL_3A:  rdata_d[7:0] = tbl3_q;
            `CFC_OFF_MODE:    rdata_d[`CFC_MODE_W-1:0] = mode_q;
            `CFC_OFF_PATTERN: rdata_d[`CFC_PAT_W-1:0] = pattern_q;
            `CFC_OFF_PLEN:    rdata_d[`CFC_PLEN_W-1:0] = plen_q;
            `CFC_OFF_STATUS:
            begin
                rdata_d[4:0] = {three_out_o, pattern_out_o, out2_q};
                rdata_d[`CFC_STAT_IDX_LO+3:`CFC_STAT_IDX_LO] = pg_idx_q;
            end
            default:          rdata_d = 32'h0000_0000;
        endcase
    end

    // One wait state: ack follows the taken edge, then drops.
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else if (clk_en_i)
        begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i)
                rdata_q <= rdata_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_table_a_select: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && !mode_q[`CFC_MODE_SEQ_LO]
        |=> table_a_out_o == $past(tbl2_q[0][table_a_in_i]))
        else $error("table A output differs from selected entry");

    a_table_b_select: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && !mode_q[`CFC_MODE_SEQ_LO+1]
        |=> table_b_out_o == $past(tbl2_q[1][table_b_in_i]))
        else $error("table B output differs from selected entry");

    a_flop_a_edge: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && mode_q[`CFC_MODE_SEQ_LO] && !mode_q[`CFC_MODE_LAT_LO]
        && rise2[0] ##1 clk_en_i
        |=> table_a_out_o == $past(table_a_in_i[0], 2))
        else $error("flop A did not load data on rising edge");

    a_flop_a_hold: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && mode_q[`CFC_MODE_SEQ_LO] && !mode_q[`CFC_MODE_LAT_LO]
        && !rise2[0] |=> $stable(q2_q[0]))
        else $error("flop A changed without a rising edge");

    a_latch_a_hold: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && mode_q[`CFC_MODE_SEQ_LO] && mode_q[`CFC_MODE_LAT_LO]
        && table_a_in_i[1] |=> $stable(q2_q[0]))
        else $error("latch A changed while clock high");

    a_pattern_reset: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && pg_rst_act |=> pg_idx_q == 4'h0)
        else $error("pattern index not cleared by reset");

    a_pattern_wrap: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && pg_state_q == cfc_pkg::PG_RUN && pg_en && !pg_rst_act
        && pg_rise |=> pg_idx_q == ($past(pg_last) ? 4'h0
                                    : $past(pg_idx_q) + 4'h1))
        else $error("pattern index stepped wrongly");

    a_split_fall: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && c3_seq && !c3_lat && c3_split && !c3_sr_act
        && c3_fall |=> c3_q_q == $past(c3_cap_q))
        else $error("split flop did not present on falling edge");

    a_split_rise_hold: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && c3_seq && !c3_lat && c3_split && !c3_sr_act
        && !c3_fall |=> $stable(c3_q_q))
        else $error("split flop output moved off a falling edge");

    a_three_sr: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && c3_seq && c3_sr_act |=> c3_q_q == $past(c3_sr_val))
        else $error("set/reset did not force the flop");

    a_three_table: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && !c3_seq |=> three_out_o == $past(tbl3_q[three_in_i]))
        else $error("three-input table output differs");

    a_bus_ack: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        clk_en_i && bus_req |=> wb_ack_o ##1 !wb_ack_o || !clk_en_i)
        else $error("ack not a single cycle after request");

endmodule : combination_function_cells

`default_nettype wire

// File: src/cfc_defines.svh
// Purpose: Register offsets, field positions and reset values of the
//          combination function cells.
// Assumes: Word-aligned Wishbone byte addresses, 8 address bits decoded.
// Notes:   Definitions only.
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CFC_OFF_TBL_A    8'h00
`define CFC_OFF_TBL_B    8'h04
`define CFC_OFF_TBL_C    8'h08
`define CFC_OFF_TBL_PG   8'h0c
`define CFC_OFF_TBL_3A   8'h10
`define CFC_OFF_MODE     8'h14
`define CFC_OFF_PATTERN  8'h18
`define CFC_OFF_PLEN     8'h1c
`define CFC_OFF_STATUS   8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFC_MODE_SEQ_LO  0
`define CFC_MODE_LAT_LO  3
`define CFC_MODE_PG_EN   6
`define CFC_MODE_PG_HIGH 7
`define CFC_MODE_SEQ3    8
`define CFC_MODE_LAT3    9
`define CFC_MODE_SET3    10
`define CFC_MODE_W       11
`define CFC_T3_SR_HIGH   2
`define CFC_T3_SPLIT     4
`define CFC_PLEN_W       4
`define CFC_PAT_W        16
`define CFC_STAT_IDX_LO  8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CFC_RST_TBL2     4'h0
`define CFC_RST_TBL3     8'h00
`define CFC_RST_MODE     11'h000
`define CFC_RST_PATTERN  16'h0000
`define CFC_RST_PLEN     4'h1

`endif

// File: src/cfc_pkg.sv
// Purpose: Types shared by the combination function cells.
// Assumes: Constants live in cfc_defines.svh.
// Notes:   Nothing here is imported; users write cfc_pkg::name.
package cfc_pkg;

    // Pattern generator: held in reset, or stepping through its bits.
    typedef enum logic [0:0]
    {
        PG_HELD,
        PG_RUN
    } pg_state_e;

    // Index into the serial pattern.
    typedef logic [3:0] pg_index_t;

endpackage : cfc_pkg

// File: verif/routed_clock_src.sv
// Purpose: Routing-side source of a routed clock for the cells.
// Assumes: Runs off the core clock; high and low last HALF cycles each.
// Notes:   Stands still low while disabled, as a gated matrix net would.
`timescale 1ns/10ps
`default_nettype none

module routed_clock_src
#(
    parameter int HALF = 4
)
(
    input  wire logic core_clk_i,
    input  wire logic run_i,
    output logic      rclk_o
);
    int cnt_q;

    // Slow toggle so the cells see each level for several core cycles.
    always_ff @(posedge core_clk_i)
    begin
        if (!run_i)
        begin
            cnt_q  <= 0;
            rclk_o <= 1'b0;
        end
        else if (cnt_q == HALF - 1)
        begin
            cnt_q  <= 0;
            rclk_o <= ~rclk_o;
        end
        else
            cnt_q <= cnt_q + 1;
    end
endmodule : routed_clock_src

`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the combination function cells.
// Assumes: Outputs settle within two core cycles of their cause.
// Notes:   Bus waits are bounded; a watchdog ends a hung run.
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defines.svh"

module tb;
    logic        clk, rst, cyc, stb, we, ack, sel_clk, run, rclk, en;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, got;
    logic [1:0]  a_in, pg_in;
    logic [2:0]  t3_in;
    logic        a_o, b_o, c_o, pg_o, t3_o;
    int          err_total, checks;

    routed_clock_src u_src (.core_clk_i(clk), .run_i(run), .rclk_o(rclk));

    combination_function_cells u_dut
    (
        .core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(en),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .table_a_in_i({sel_clk ? rclk : a_in[1], a_in[0]}),
        .table_b_in_i(a_in), .table_c_in_i(a_in),
        .pattern_in_i({pg_in[1], sel_clk ? rclk : pg_in[0]}),
        .three_in_i(t3_in), .table_a_out_o(a_o), .table_b_out_o(b_o),
        .table_c_out_o(c_o), .pattern_out_o(pg_o), .three_out_o(t3_o)
    );

    // Core clock, 50 ns period.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Counts and reports one comparison.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One classic cycle; held until ack is sampled high at an edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 16)
            err_total++;
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Waits n rising edges, then samples on the falling edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Mode reset value, pattern read-back and an unmapped read.
    task automatic t_regs();
        bus(1'b0, `CFC_OFF_MODE, 32'h0);
        chk(got, 32'h0);
        bus(1'b1, `CFC_OFF_PATTERN, 32'h1234);
        bus(1'b0, `CFC_OFF_PATTERN, 32'h0);
        chk(got, 32'h1234);
        bus(1'b0, 8'h40, 32'h0);
        chk(got, 32'h0);
        $display("test regs done");
    endtask : t_regs

    // All six gates in every two-input table.
    task automatic t_tables();
        logic [3:0] g [6] = '{4'h8, 4'h7, 4'he, 4'h1, 4'h6, 4'h9};
        for (int i = 0; i < 6; i++)
        begin
            for (int j = 0; j < 4; j++)
                bus(1'b1, 8'(j * 4), {28'h0, g[i]});
            for (int k = 0; k < 4; k++)
            begin
                a_in  <= k[1:0];
                pg_in <= k[1:0];
                settle(2);
                chk({31'h0, a_o}, {31'h0, g[i][k]});
                chk({31'h0, b_o}, {31'h0, g[i][k]});
                chk({31'h0, c_o}, {31'h0, g[i][k]});
                chk({31'h0, pg_o}, {31'h0, g[i][k]});
                @(posedge clk);
            end
        end
        $display("test tables done");
    endtask : t_tables

    // Three-input table holding the XOR-3 pattern.
    task automatic t_three();
        logic [7:0] e = 8'h96;
        bus(1'b1, `CFC_OFF_TBL_3A, {24'h0, e});
        for (int k = 0; k < 8; k++)
        begin
            t3_in <= k[2:0];
            settle(2);
            chk({31'h0, t3_o}, {31'h0, e[k]});
            @(posedge clk);
        end
        // With the enable low the output must hold while inputs move.
        en    <= 1'b0;
        t3_in <= 3'b000;
        settle(2);
        chk({31'h0, t3_o}, {31'h0, e[7]});
        @(posedge clk);
        en <= 1'b1;
        $display("test three done");
    endtask : t_three

    // Three-input cell: split-edge flop, set/reset, then plain flop.
    task automatic t_split();
        bus(1'b1, `CFC_OFF_MODE, 32'h100);
        t3_in <= 3'b011;
        settle(2);
        chk({31'h0, t3_o}, 32'h0);
        @(posedge clk);
        t3_in <= 3'b000;
        settle(2);
        chk({31'h0, t3_o}, 32'h1);
        @(posedge clk);
        t3_in <= 3'b100;
        settle(2);
        chk({31'h0, t3_o}, 32'h0);
        @(posedge clk);
        bus(1'b1, `CFC_OFF_TBL_3A, 32'h4);
        t3_in <= 3'b011;
        settle(2);
        chk({31'h0, t3_o}, 32'h1);
        @(posedge clk);
        $display("test split done");
    endtask : t_split

    // Cell A as flop: capture on the rise, hold while data moves.
    task automatic t_flop();
        logic [5:0] d = 6'b101100;
        bus(1'b1, `CFC_OFF_MODE, 32'h1);
        sel_clk <= 1'b1;
        run     <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            @(negedge rclk);
            @(posedge clk);
            a_in[0] <= d[i];
            @(posedge rclk);
            settle(2);
            chk({31'h0, a_o}, {31'h0, d[i]});
            @(posedge clk);
            a_in[0] <= ~d[i];
            settle(2);
            chk({31'h0, a_o}, {31'h0, d[i]});
        end
        @(posedge clk);
        run <= 1'b0;
        $display("test flop done");
    endtask : t_flop

    // Cell A as latch: open while the routed clock is low.
    task automatic t_latch();
        bus(1'b1, `CFC_OFF_MODE, 32'h9);
        a_in[0] <= 1'b1;
        settle(3);
        chk({31'h0, a_o}, 32'h1);
        @(posedge clk);
        a_in[0] <= 1'b0;
        run     <= 1'b1;
        @(posedge rclk);
        @(posedge clk);
        a_in[0] <= 1'b1;
        settle(2);
        chk({31'h0, a_o}, 32'h0);
        settle(3);
        chk({31'h0, a_o}, 32'h1);
        @(posedge clk);
        run <= 1'b0;
        $display("test latch done");
    endtask : t_latch

    // Four-bit pattern, high then low reset level.
    task automatic t_pattern();
        logic [15:0] p = 16'h0009;
        pg_in[1] <= 1'b1;
        bus(1'b1, `CFC_OFF_PATTERN, {16'h0, p});
        bus(1'b1, `CFC_OFF_PLEN, 32'h3);
        bus(1'b1, `CFC_OFF_MODE, 32'hc0);
        run <= 1'b1;
        repeat (2) @(posedge rclk);
        settle(3);
        chk({31'h0, pg_o}, {31'h0, p[0]});
        @(negedge rclk);
        @(posedge clk);
        pg_in[1] <= 1'b0;
        for (int k = 1; k < 10; k++)
        begin
            @(posedge rclk);
            settle(3);
            chk({31'h0, pg_o}, {31'h0, p[k % 4]});
        end
        @(posedge clk);
        run <= 1'b0;
        bus(1'b1, `CFC_OFF_MODE, 32'h40);
        run <= 1'b1;
        repeat (2) @(posedge rclk);
        settle(3);
        chk({31'h0, pg_o}, {31'h0, p[0]});
        $display("test pattern done");
    endtask : t_pattern

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Main sequence after a twelve-cycle reset.
    initial
    begin
        {rst, cyc, stb, we, sel_clk, run} = 6'h20;
        en = 1'b1;
        {sel, adr, wdat, a_in, pg_in, t3_in} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_tables();
        t_three();
        t_split();
        t_flop();
        t_latch();
        t_pattern();
        wrap_up();
    end

    // Watchdog, over forty times the expected run length.
    initial
    begin
        #1_000_000;
        err_total++;
        wrap_up();
    end
endmodule : tb

`default_nettype wire
